//--- hw/cag_defs.svh
// constants of the cpu address generation block
`ifndef CAG_DEFS_SVH
`define CAG_DEFS_SVH
`define CAG_CSP_ADDR  16'hfe08
`define CAG_DATA_PAGE_REGISTER_0_ADDR 16'hfe20
`define CAG_DATA_PAGE_REGISTER_1_ADDR 16'hfe22
`define CAG_DATA_PAGE_REGISTER_2_ADDR 16'hfe24
`define CAG_DATA_PAGE_REGISTER_3_ADDR 16'hfe26
`define CAG_CSP_RST   8'h00
`define CAG_IP_RST    16'h0000
`define CAG_LVL_RST   4'h0
`define CAG_LVL_TOP   4'hf
`define CAG_DATA_PAGE_REGISTER_0_RST  10'h000
`define CAG_DATA_PAGE_REGISTER_1_RST  10'h001
`define CAG_DATA_PAGE_REGISTER_2_RST  10'h002
`define CAG_DATA_PAGE_REGISTER_3_RST  10'h003
`endif

//--- hw/cag_pkg.sv
// types of the cpu address generation block
package cag_pkg;
	typedef enum logic [1:0] {CAG_SEGW_8, CAG_SEGW_4, CAG_SEGW_2} cag_segw_e;
	typedef enum logic [1:0] {CAG_DK_LONG, CAG_DK_OVERRIDE, CAG_DK_PEC} cag_dkind_e;
	typedef logic [9:0] cag_page_t;
	typedef struct packed {
		logic            global_interrupt_enable;
		logic [3:0]      level;
		logic [15:0]     ip;
		logic [7:0]      code_segment_register;
		cag_page_t [3:0] dpp;
		cag_page_t [3:0] dpp_stage;
		cag_page_t [3:0] dpp_eff;
		logic [15:0]     rdata;
		logic [23:0]     data_phys;
		logic            data_valid;
		logic [7:0]      ext_seg;
		logic            ext_seg_en;
	} cag_state_s;
endpackage : cag_pkg

//--- hw/cag_xl_if.sv
// carrier between the core and the page translator
`timescale 1ns/1ps
interface cag_xl_if;
	import cag_pkg::*;
	cag_page_t [3:0] page;
	logic            seg_mode;
	logic [15:0]     addr16;
	cag_dkind_e      kind;
	cag_page_t       ovr_page;
	logic [23:0]     phys;
	cag_page_t       sel_page;
	modport core (output page, seg_mode, addr16, kind, ovr_page, input phys, sel_page);
	modport xl (input page, seg_mode, addr16, kind, ovr_page, output phys, sel_page);
endinterface : cag_xl_if

//--- hw/cag_page_xlate.sv
// data page translation of a 16-bit data address
`timescale 1ns/1ps
module cag_page_xlate (
	cag_xl_if.xl xl
);
	import cag_pkg::*;

	always_comb
	begin
		xl.sel_page = xl.page[xl.addr16[15:14]];
		xl.phys     = {8'h00, xl.addr16};
		unique case (xl.kind)
		CAG_DK_LONG:
		begin
			if (xl.seg_mode)
				xl.phys = {xl.sel_page, xl.addr16[13:0]};
			else
				xl.phys = {8'h00, xl.sel_page[1:0], xl.addr16[13:0]};
		end
		CAG_DK_OVERRIDE:
		begin
			xl.sel_page = xl.ovr_page;
			xl.phys     = {xl.ovr_page, xl.addr16[13:0]};
		end
		default:
		begin
			// peripheral event transfers stay flat in segment 0
			xl.sel_page = '0;
			xl.phys     = {8'h00, xl.addr16};
		end
		endcase
	end
endmodule : cag_page_xlate

//--- hw/cag_core.sv
// interrupt status, fetch offset, code segment and data page logic
`timescale 1ns/1ps
`include "cag_defs.svh"
module cag_core (
	// clock and reset
	input  logic               clk,
	input  logic               rst,
	// memory mode
	input  logic               seg_mode,
	input  cag_pkg::cag_segw_e seg_width,
	// interrupt status
	input  logic               psw_wr,
	input  logic               psw_ien,
	input  logic [3:0]         psw_level,
	input  logic               irq_req,
	input  logic [3:0]         irq_level,
	input  logic               nmi_req,
	input  logic               trap_hw_req,
	output logic               irq_grant,
	output logic               ien_out,
	output logic [3:0]         level_out,
	// interrupt and trap entry
	input  logic               intr_accept,
	input  logic [3:0]         intr_level,
	input  logic               trap_sw,
	input  logic [15:0]        vector_off,
	// code flow
	input  logic               fetch_adv,
	input  logic [3:0]         fetch_step,
	input  logic               branch_take,
	input  logic [15:0]        branch_off,
	input  logic               far_take,
	input  logic [7:0]         far_seg,
	input  logic [15:0]        far_off,
	input  logic               ret_take,
	input  logic [15:0]        ret_off,
	input  logic               instr_end,
	// code address
	input  logic               code_ext,
	output logic [23:0]        code_addr,
	// data address
	input  logic               data_req,
	input  cag_pkg::cag_dkind_e data_kind,
	input  logic [15:0]        data_addr,
	input  cag_pkg::cag_page_t data_ovr_page,
	input  logic               data_ext,
	output logic [23:0]        data_phys,
	output logic               data_valid,
	// special function register access
	input  logic [15:0]        sfr_addr,
	input  logic               sfr_wr,
	input  logic [15:0]        sfr_wdata,
	input  logic               sfr_rd,
	output logic [15:0]        sfr_rdata,
	// upper external address pins
	output logic [7:0]         ext_seg_out,
	output logic               ext_seg_en
);
	import cag_pkg::*;

	cag_state_s s_reg;
	cag_state_s s_next;
	cag_xl_if   xl ();

	// low bits of a segment or page field as the pin width asks
	function automatic logic [7:0] seg_bits(input logic [7:0] v, input cag_segw_e w);
		logic [7:0] r;
		r = v;
		unique case (w)
		CAG_SEGW_8: r = v;
		CAG_SEGW_4: r = {4'h0, v[3:0]};
		CAG_SEGW_2: r = {6'h00, v[1:0]};
		default:    r = v;
		endcase
		return r;
	endfunction : seg_bits

	cag_page_xlate u_xlate (
		.xl (xl.xl)
	);

	assign xl.page     = s_reg.dpp_eff;
	assign xl.seg_mode = seg_mode;
	assign xl.addr16   = data_addr;
	assign xl.kind     = data_kind;
	assign xl.ovr_page = data_ovr_page;

	assign irq_grant = trap_hw_req | nmi_req | (s_reg.global_interrupt_enable & irq_req
		& (s_reg.level != `CAG_LVL_TOP) & (irq_level > s_reg.level));
	assign ien_out   = s_reg.global_interrupt_enable;
	assign level_out = s_reg.level;

	assign code_addr   = seg_mode ? {s_reg.code_segment_register, s_reg.ip} : {8'h00, s_reg.ip};
	assign data_phys   = s_reg.data_phys;
	assign data_valid  = s_reg.data_valid;
	assign sfr_rdata   = s_reg.rdata;
	assign ext_seg_out = s_reg.ext_seg;
	assign ext_seg_en  = s_reg.ext_seg_en;

	always_comb
	begin
		s_next            = s_reg;
		s_next.data_valid = 1'b0;
		if (intr_accept)
			s_next.level = intr_level;
		else if (psw_wr)
		begin
			s_next.global_interrupt_enable   = psw_ien;
			s_next.level = psw_level;
		end
		if (intr_accept || trap_sw)
		begin
			s_next.code_segment_register = `CAG_CSP_RST;
			s_next.ip  = vector_off;
		end
		else if (far_take)
		begin
			s_next.code_segment_register = far_seg;
			s_next.ip  = far_off;
		end
		else if (ret_take)
			s_next.ip = ret_off;
		else if (branch_take)
			s_next.ip = branch_off;
		else if (fetch_adv)
			s_next.ip = s_reg.ip + 16'(fetch_step);
		if (sfr_wr)
		begin
			unique case (sfr_addr)
			`CAG_DATA_PAGE_REGISTER_0_ADDR: s_next.dpp[0] = sfr_wdata[9:0];
			`CAG_DATA_PAGE_REGISTER_1_ADDR: s_next.dpp[1] = sfr_wdata[9:0];
			`CAG_DATA_PAGE_REGISTER_2_ADDR: s_next.dpp[2] = sfr_wdata[9:0];
			`CAG_DATA_PAGE_REGISTER_3_ADDR: s_next.dpp[3] = sfr_wdata[9:0];
			default:        s_next.dpp    = s_reg.dpp;
			endcase
		end
		if (instr_end)
		begin
			s_next.dpp_stage = s_reg.dpp;
			s_next.dpp_eff   = s_reg.dpp_stage;
		end
		if (sfr_rd)
		begin
			unique case (sfr_addr)
			`CAG_CSP_ADDR:  s_next.rdata = {8'h00, s_reg.code_segment_register};
			`CAG_DATA_PAGE_REGISTER_0_ADDR: s_next.rdata = {6'h00, s_reg.dpp[0]};
			`CAG_DATA_PAGE_REGISTER_1_ADDR: s_next.rdata = {6'h00, s_reg.dpp[1]};
			`CAG_DATA_PAGE_REGISTER_2_ADDR: s_next.rdata = {6'h00, s_reg.dpp[2]};
			`CAG_DATA_PAGE_REGISTER_3_ADDR: s_next.rdata = {6'h00, s_reg.dpp[3]};
			default:        s_next.rdata = 16'h0000;
			endcase
		end
		if (data_req)
		begin
			s_next.data_phys  = xl.phys;
			s_next.data_valid = 1'b1;
		end
		s_next.ext_seg    = 8'h00;
		s_next.ext_seg_en = 1'b0;
		if (seg_mode && data_req && data_ext)
		begin
			s_next.ext_seg    = seg_bits(xl.sel_page[9:2], seg_width);
			s_next.ext_seg_en = 1'b1;
		end
		else if (seg_mode && code_ext)
		begin
			s_next.ext_seg    = seg_bits(s_reg.code_segment_register, seg_width);
			s_next.ext_seg_en = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_reg            <= '0;
			s_reg.level      <= `CAG_LVL_RST;
			s_reg.ip         <= `CAG_IP_RST;
			s_reg.code_segment_register        <= `CAG_CSP_RST;
			s_reg.dpp        <= {`CAG_DATA_PAGE_REGISTER_3_RST, `CAG_DATA_PAGE_REGISTER_2_RST, `CAG_DATA_PAGE_REGISTER_1_RST, `CAG_DATA_PAGE_REGISTER_0_RST};
			s_reg.dpp_stage  <= {`CAG_DATA_PAGE_REGISTER_3_RST, `CAG_DATA_PAGE_REGISTER_2_RST, `CAG_DATA_PAGE_REGISTER_1_RST, `CAG_DATA_PAGE_REGISTER_0_RST};
			s_reg.dpp_eff    <= {`CAG_DATA_PAGE_REGISTER_3_RST, `CAG_DATA_PAGE_REGISTER_2_RST, `CAG_DATA_PAGE_REGISTER_1_RST, `CAG_DATA_PAGE_REGISTER_0_RST};
		end
		else
			s_reg <= s_next;
	end

	logic quiet_flow;
	assign quiet_flow = !intr_accept && !trap_sw && !far_take && !ret_take && !branch_take;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	irq_enable_gate_a: assert property (
		irq_grant && !trap_hw_req && !nmi_req |-> ien_out && irq_level > level_out)
		else $error("maskable grant without enable");
	level_load_a: assert property (
		intr_accept |=> level_out == $past(intr_level))
		else $error("level not loaded on entry");
	sw_level_a: assert property (
		psw_wr && !intr_accept |=> level_out == $past(psw_level) && ien_out == $past(psw_ien))
		else $error("software level write lost");
	top_level_a: assert property (
		level_out == `CAG_LVL_TOP && irq_grant |-> trap_hw_req || nmi_req)
		else $error("preempted at top level");
	reset_status_a: assert property (
		$past(rst) |-> !ien_out && level_out == 4'h0)
		else $error("bad interrupt status after reset");
	offset_sfr_a: assert property (
		quiet_flow && !fetch_adv |=> code_addr[15:0] == $past(code_addr[15:0]))
		else $error("fetch offset changed without flow");
	ret_offset_a: assert property (
		ret_take && !intr_accept && !trap_sw && !far_take |=> s_reg.ip == $past(ret_off))
		else $error("return offset not loaded");
	fetch_step_a: assert property (
		fetch_adv && quiet_flow |=> s_reg.ip == $past(s_reg.ip) + 16'($past(fetch_step)))
		else $error("fetch offset did not advance");
	branch_off_a: assert property (
		branch_take && !intr_accept && !trap_sw && !far_take && !ret_take
		|=> s_reg.ip == $past(branch_off))
		else $error("branch target not loaded");
	csp_read_a: assert property (
		sfr_rd && sfr_addr == `CAG_CSP_ADDR |=> sfr_rdata == {8'h00, $past(s_reg.code_segment_register)})
		else $error("code segment read wrong");
	far_seg_a: assert property (
		far_take && !intr_accept && !trap_sw ##1 seg_mode
		|-> code_addr == {$past(far_seg), $past(far_off)})
		else $error("far code address wrong");
	code_pins_a: assert property (
		seg_mode && code_ext && !(data_req && data_ext) && seg_width == CAG_SEGW_4
		|=> ext_seg_en && ext_seg_out == {4'h0, $past(s_reg.code_segment_register[3:0])})
		else $error("segment pins wrong");
	flat_code_a: assert property (
		!seg_mode |-> code_addr[23:16] == 8'h00)
		else $error("segment used when unsegmented");
	flat_pins_a: assert property (
		!seg_mode |=> !ext_seg_en)
		else $error("pins driven when unsegmented");
	csp_ro_a: assert property (
		sfr_wr && sfr_addr == `CAG_CSP_ADDR && !intr_accept && !trap_sw && !far_take
		|=> s_reg.code_segment_register == $past(s_reg.code_segment_register))
		else $error("data write reached code segment");
	csp_clear_a: assert property (
		intr_accept || trap_sw |=> s_reg.code_segment_register == 8'h00)
		else $error("segment not cleared on entry");
	page_wr_a: assert property (
		sfr_wr && sfr_addr == `CAG_DATA_PAGE_REGISTER_2_ADDR ##1 sfr_rd && sfr_addr == `CAG_DATA_PAGE_REGISTER_2_ADDR
		|=> sfr_rdata == {6'h00, $past(sfr_wdata[9:0], 2)})
		else $error("page register write lost");
	pec_flat_a: assert property (
		data_req && data_kind == CAG_DK_PEC |=> data_valid && data_phys == {8'h00, $past(data_addr)})
		else $error("event transfer was paged");
	reset_pages_a: assert property (
		$past(rst) |-> s_reg.dpp_eff == {10'h003, 10'h002, 10'h001, 10'h000})
		else $error("pages not identity after reset");
	page_form_a: assert property (
		data_req && data_kind == CAG_DK_LONG && seg_mode |=> data_valid
		&& data_phys == {$past(s_reg.dpp_eff[data_addr[15:14]]), $past(data_addr[13:0])})
		else $error("paged address wrong");
	two_bits_a: assert property (
		data_req && data_kind == CAG_DK_LONG && !seg_mode
		|=> data_phys[23:16] == 8'h00 && data_phys[15:14] == $past(xl.sel_page[1:0]))
		else $error("unsegmented page uses upper bits");
	data_pins_a: assert property (
		seg_mode && data_req && data_ext && seg_width == CAG_SEGW_8
		|=> ext_seg_en && ext_seg_out == $past(xl.sel_page[9:2]))
		else $error("page pins wrong");
	page_lag_a: assert property (
		sfr_wr && sfr_addr == `CAG_DATA_PAGE_REGISTER_1_ADDR && !instr_end
		&& s_reg.dpp_stage[1] == s_reg.dpp_eff[1] ##1 !instr_end[*2] ##1 instr_end
		|=> s_reg.dpp_eff[1] == $past(s_reg.dpp_eff[1]))
		else $error("next instruction saw new page");
	reserved_rd_a: assert property (
		sfr_rd |=> sfr_rdata[15:10] == 6'h00)
		else $error("reserved bits read nonzero");

	// state moves only on its own strobes; override accesses take the given page
	ien_hold_a: assert property (
		!psw_wr |=> ien_out == $past(ien_out))
		else $error("global enable moved without write");
	level_hold_a: assert property (
		!psw_wr && !intr_accept |=> level_out == $past(level_out))
		else $error("priority level moved without cause");
	csp_hold_a: assert property (
		!intr_accept && !trap_sw && !far_take |=> s_reg.code_segment_register == $past(s_reg.code_segment_register))
		else $error("code segment moved without far flow");
	rdata_hold_a: assert property (
		!sfr_rd |=> sfr_rdata == $past(sfr_rdata))
		else $error("read data moved without read");
	ovr_form_a: assert property (
		data_req && data_kind == CAG_DK_OVERRIDE
		|=> data_valid && data_phys == {$past(data_ovr_page), $past(data_addr[13:0])})
		else $error("override address wrong");
	valid_pulse_a: assert property (
		!data_req |=> !data_valid)
		else $error("data valid without request");
	pin_release_a: assert property (
		!code_ext && !(data_req && data_ext) |=> !ext_seg_en)
		else $error("pins driven without external access");

	grant_cover_c: cover property (irq_req && irq_grant && level_out != 4'h0);
	far_fetch_c: cover property (far_take ##1 fetch_adv ##1 code_ext && seg_mode);
	page_use_c: cover property (sfr_wr ##1 instr_end ##[1:4] instr_end ##1 data_req && data_ext);
	top_block_c: cover property (level_out == `CAG_LVL_TOP && irq_req && !irq_grant);
endmodule : cag_core

//--- tb/cag_seq_model.sv
// sequencer and bus controller model: sfr strobes, data requests, instruction ends
`timescale 1ns/1ps
module cag_seq_model
	import cag_pkg::*;
(
	// clock
	input  logic                clk,
	// sfr bus
	output logic [15:0]         sfr_addr,
	output logic                sfr_wr,
	output logic [15:0]         sfr_wdata,
	output logic                sfr_rd,
	// data request
	output logic                data_req,
	output cag_pkg::cag_dkind_e data_kind,
	output logic [15:0]         data_addr,
	output cag_pkg::cag_page_t  data_ovr_page,
	output logic                data_ext,
	// instruction boundary
	output logic                instr_end
);
	initial
	begin
		{sfr_addr, sfr_wr, sfr_wdata, sfr_rd} = 34'h0_0000_0000;
		{data_req, data_addr, data_ovr_page, data_ext, instr_end} = 29'h0000_0000;
		data_kind = CAG_DK_LONG;
		rel_t = -1.0;
	end

	realtime rel_t;

	// an idle edge keeps a signal from changing twice in one step
	task settle;
		if ($realtime == rel_t)
		begin
			@(posedge clk);
			#1;
		end
	endtask : settle

	task sfr_write(input logic [15:0] a, input logic [15:0] d);
		settle;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
		rel_t = $realtime;
	endtask : sfr_write

	// write, then read back on the next edge with the address held
	task sfr_write_read(input logic [15:0] a, input logic [15:0] d);
		settle;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		rel_t = $realtime;
	endtask : sfr_write_read

	task sfr_read(input logic [15:0] a);
		settle;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		rel_t = $realtime;
	endtask : sfr_read

	task xlate(input cag_dkind_e k, input logic [15:0] a, input cag_page_t p, input logic e);
		settle;
		data_kind = k;
		data_addr = a;
		data_ovr_page = p;
		data_ext = e;
		data_req = 1'b1;
		@(posedge clk);
		#1;
		data_req = 1'b0;
		data_addr = ~a;
		data_ovr_page = ~p;
		rel_t = $realtime;
	endtask : xlate

	task iend;
		instr_end = 1'b1;
		@(posedge clk);
		#1;
		instr_end = 1'b0;
	endtask : iend
endmodule : cag_seq_model

//--- tb/cpu_address_generation_tb.sv
// self-checking bench of the cpu address generation core
`timescale 1ns/1ps
`include "cag_defs.svh"
module cpu_address_generation_tb;
	import cag_pkg::*;
	logic        clk, rst, seg_mode, psw_wr, psw_ien, irq_req, nmi_req, trap_hw_req;
	logic        intr_accept, trap_sw, fetch_adv, branch_take, far_take, ret_take, code_ext;
	logic        irq_grant, ien_out, data_valid, ext_seg_en, sfr_wr, sfr_rd, data_req;
	logic        data_ext, instr_end;
	logic [3:0]  psw_level, irq_level, intr_level, fetch_step, level_out;
	logic [7:0]  far_seg, ext_seg_out;
	logic [15:0] vector_off, branch_off, far_off, ret_off, data_addr, sfr_addr, sfr_wdata;
	logic [15:0] sfr_rdata;
	logic [23:0] code_addr, data_phys;
	cag_segw_e   seg_width;
	cag_dkind_e  data_kind;
	cag_page_t   data_ovr_page;
	int          failures, tests_run;

	cag_core cag_core_i (.clk, .rst, .seg_mode, .seg_width, .psw_wr, .psw_ien, .psw_level,
		.irq_req, .irq_level, .nmi_req, .trap_hw_req, .irq_grant, .ien_out, .level_out,
		.intr_accept, .intr_level, .trap_sw, .vector_off, .fetch_adv, .fetch_step,
		.branch_take, .branch_off, .far_take, .far_seg, .far_off, .ret_take, .ret_off,
		.instr_end, .code_ext, .code_addr, .data_req, .data_kind, .data_addr, .data_ovr_page,
		.data_ext, .data_phys, .data_valid, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
		.sfr_rdata, .ext_seg_out, .ext_seg_en);
	cag_seq_model cag_seq_model_i (.clk, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .data_req,
		.data_kind, .data_addr, .data_ovr_page, .data_ext, .instr_end);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk_addr(input string n, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk_addr

	task chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk_word

	task chk_bit(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %b seen %b", n, e, g);
		end
	endtask : chk_bit

	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	task tick;
		@(posedge clk);
		#1;
	endtask : tick

	// k picks fetch, branch, return, far, interrupt or trap
	task flow(input int k, input logic [15:0] off);
		{trap_sw, intr_accept, far_take, ret_take, branch_take, fetch_adv} = 6'(1 << k);
		{vector_off, far_off, ret_off, branch_off} = {4{off}};
		tick;
		{trap_sw, intr_accept, far_take, ret_take, branch_take, fetch_adv} = 6'h00;
		tick;
	endtask : flow

	task psw(input logic en, input logic [3:0] lv);
		{psw_wr, psw_ien, psw_level} = {1'b1, en, lv};
		tick;
		psw_wr = 1'b0;
	endtask : psw

	task grant(input logic [3:0] lv, input logic [1:0] nt, input logic e);
		irq_level = lv;
		{nmi_req, trap_hw_req} = nt;
		tick;
		chk_bit("grant", e, irq_grant);
	endtask : grant

	task t_reset;
		chk_bit("ien", 1'b0, ien_out);
		chk_word("level", 16'h0000, {12'h000, level_out});
		for (int i = 0; i < 4; i++)
		begin
			cag_seq_model_i.sfr_read(`CAG_DATA_PAGE_REGISTER_0_ADDR + 16'(2 * i));
			chk_word("page reset", 16'(i), sfr_rdata);
			cag_seq_model_i.xlate(CAG_DK_LONG, {i[1:0], 14'h0123}, 10'h000, 1'b0);
			chk_addr("identity", {8'h00, i[1:0], 14'h0123}, data_phys);
		end
		$display("t_reset done");
	endtask : t_reset

	task t_regs;
		cag_seq_model_i.sfr_write_read(`CAG_DATA_PAGE_REGISTER_2_ADDR, 16'hffff);
		chk_word("page bits", 16'h03ff, sfr_rdata);
		cag_seq_model_i.sfr_write_read(`CAG_CSP_ADDR, 16'h00ff);
		chk_word("segment write", 16'h0000, sfr_rdata);
		cag_seq_model_i.sfr_read(16'hfe00);
		chk_word("unmapped", 16'h0000, sfr_rdata);
		$display("t_regs done");
	endtask : t_regs

	task t_lag;
		seg_mode = 1'b1;
		cag_seq_model_i.sfr_write(`CAG_DATA_PAGE_REGISTER_1_ADDR, 16'h0156);
		cag_seq_model_i.xlate(CAG_DK_LONG, 16'h4007, 10'h000, 1'b0);
		chk_addr("page same instr", 24'h00_4007, data_phys);
		cag_seq_model_i.iend;
		cag_seq_model_i.xlate(CAG_DK_LONG, 16'h4007, 10'h000, 1'b0);
		chk_addr("page next instr", 24'h00_4007, data_phys);
		cag_seq_model_i.iend;
		cag_seq_model_i.xlate(CAG_DK_LONG, 16'h4007, 10'h000, 1'b0);
		chk_addr("page seg", 24'h55_8007, data_phys);
		chk_bit("valid", 1'b1, data_valid);
		seg_mode = 1'b0;
		cag_seq_model_i.xlate(CAG_DK_LONG, 16'h4007, 10'h000, 1'b0);
		chk_addr("page unseg", 24'h00_8007, data_phys);
		cag_seq_model_i.xlate(CAG_DK_OVERRIDE, 16'h4007, 10'h2aa, 1'b0);
		chk_addr("override", 24'haa_8007, data_phys);
		cag_seq_model_i.xlate(CAG_DK_PEC, 16'h800d, 10'h000, 1'b0);
		chk_addr("event xfer", 24'h00_800d, data_phys);
		$display("t_lag done");
	endtask : t_lag

	task t_code;
		seg_mode = 1'b1;
		flow(3, 16'h1234);
		chk_addr("far", 24'ha5_1234, code_addr);
		cag_seq_model_i.sfr_read(`CAG_CSP_ADDR);
		chk_word("segment read", 16'h00a5, sfr_rdata);
		flow(0, 16'h0000);
		chk_addr("fetch", 24'ha5_1236, code_addr);
		flow(1, 16'h2000);
		chk_addr("branch", 24'ha5_2000, code_addr);
		flow(2, 16'h3456);
		chk_addr("return", 24'ha5_3456, code_addr);
		seg_mode = 1'b0;
		tick;
		chk_addr("unseg code", 24'h00_3456, code_addr);
		$display("t_code done");
	endtask : t_code

	task t_pins;
		logic [7:0] dpin [3] = '{8'hff, 8'h0f, 8'h03};
		logic [7:0] cpin [3] = '{8'ha5, 8'h05, 8'h01};
		code_ext = 1'b1;
		tick;
		code_ext = 1'b0;
		chk_bit("pins unseg", 1'b0, ext_seg_en);
		seg_mode = 1'b1;
		for (int w = 0; w < 3; w++)
		begin
			seg_width = cag_segw_e'(w);
			cag_seq_model_i.xlate(CAG_DK_LONG, 16'h8000, 10'h000, 1'b1);
			chk_word("data pins", {8'h01, dpin[w]}, {7'h00, ext_seg_en, ext_seg_out});
			code_ext = 1'b1;
			tick;
			code_ext = 1'b0;
			chk_word("code pins", {8'h01, cpin[w]}, {7'h00, ext_seg_en, ext_seg_out});
		end
		tick;
		chk_bit("pins release", 1'b0, ext_seg_en);
		$display("t_pins done");
	endtask : t_pins

	task t_irq;
		psw(1'b1, 4'h5);
		chk_bit("ien set", 1'b1, ien_out);
		chk_word("level sw", 16'h0005, {12'h000, level_out});
		irq_req = 1'b1;
		grant(4'h6, 2'b00, 1'b1);
		grant(4'h5, 2'b00, 1'b0);
		psw(1'b0, 4'h5);
		grant(4'h6, 2'b00, 1'b0);
		psw(1'b1, 4'hf);
		grant(4'hf, 2'b00, 1'b0);
		grant(4'hf, 2'b10, 1'b1);
		grant(4'hf, 2'b01, 1'b1);
		flow(4, 16'h0040);
		chk_addr("intr entry", 24'h00_0040, code_addr);
		chk_word("level hw", 16'h0009, {12'h000, level_out});
		flow(3, 16'h1234);
		flow(5, 16'h0080);
		chk_addr("trap entry", 24'h00_0080, code_addr);
		$display("t_irq done");
	endtask : t_irq

	initial
	begin
		#100000;
		failures++;
		give_verdict;
	end

	initial
	begin
		{seg_mode, psw_wr, psw_ien, irq_req, nmi_req, trap_hw_req, code_ext} = 7'h00;
		{trap_sw, intr_accept, far_take, ret_take, branch_take, fetch_adv} = 6'h00;
		{psw_level, irq_level} = 8'h00;
		{vector_off, branch_off, far_off, ret_off} = 64'h0;
		intr_level = 4'h9;
		fetch_step = 4'h2;
		far_seg = 8'ha5;
		seg_width = CAG_SEGW_8;
		failures = 0;
		tests_run = 0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		tick;
		t_reset;
		t_regs;
		t_lag;
		t_code;
		t_pins;
		t_irq;
		give_verdict;
	end
endmodule : cpu_address_generation_tb
